// ### hdl/mbr_pkg.sv
// Shared constants, types and helpers of the matrix bit rotator
package mbr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte addresses on the APB slave
    localparam logic [7:0]  ADDR_CTRL      = 8'h00; // Start and direction
    localparam logic [7:0]  ADDR_SRC       = 8'h04; // First source row
    localparam logic [7:0]  ADDR_DST       = 8'h08; // First destination row
    localparam logic [7:0]  ADDR_LEN       = 8'h0C; // Row count
    localparam logic [7:0]  ADDR_STATUS    = 8'h10; // Busy, error, carry
    localparam logic [7:0]  ADDR_ERRCODE   = 8'h14; // Error code register
    localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h18; // Sticky event bits
    localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h1C; // Event enables

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int          CTRL_START_BIT = 0;     // Write 1 to start
    localparam int          CTRL_DIR_BIT   = 1;     // Direction select flag
    localparam int          STAT_BUSY_BIT  = 0;     // Operation running
    localparam int          STAT_ERR_BIT   = 1;     // Error flag, W1C
    localparam int          STAT_CARRY_BIT = 2;     // Matrix carry flag
    localparam int          IRQ_DONE_BIT   = 0;     // Operation finished
    localparam int          IRQ_ERR_BIT    = 1;     // Operation refused
    localparam int          IRQ_W          = 2;     // Number of events

    ////////////////////////////////////////////////////////////////////////
    // Operand limits and error codes
    localparam logic [15:0] ROWS_MIN       = 16'h0001; // Least row count
    localparam logic [15:0] ROWS_MAX       = 16'h0100; // Largest row count
    localparam logic [16:0] AREA_LAST      = 17'h0FFFF; // Last word address
    localparam logic [15:0] ERR_RANGE      = 16'h2003; // Row out of area
    localparam logic [15:0] ERR_OPERAND    = 16'h200B; // Bad row count

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [15:0] RST_WORD       = 16'h0000; // Word registers
    localparam logic [15:0] RST_LEN        = 16'h0001; // Row count
    localparam logic        RST_BIT        = 1'b0;     // Single flags
    localparam logic [IRQ_W-1:0] RST_IRQ   = 2'h0;     // Event bits

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        ST_IDLE,                                    // Waiting for start
        ST_EDGE,                                    // Fetch the wrap bit
        ST_READ,                                    // Read one source row
        ST_WRITE                                    // Write one result row
    } mbr_state_e;

    typedef struct packed {
        logic        req;                           // Request pending
        logic        we;                            // 1 write, 0 read
        logic [15:0] addr;                          // Word address
        logic [15:0] wdata;                         // Write data
    } mbr_mem_req_s;

    typedef struct packed {
        logic        ack;                           // Request completes
        logic [15:0] rdata;                         // Read data
    } mbr_mem_rsp_s;

    ////////////////////////////////////////////////////////////////////////
    // Address of the last row of an area, one bit wider to show overflow
    function automatic logic [16:0] mbr_last_row(input logic [15:0] base,
                                                 input logic [15:0] rows);
        mbr_last_row = {1'b0, base} + {1'b0, rows} - 17'h00001;
    endfunction

    // Address of row k of an area
    function automatic logic [15:0] mbr_row_addr(input logic [15:0] base,
                                                 input logic [7:0]  k);
        mbr_row_addr = base + {8'h00, k};
    endfunction

endpackage

// ### hdl/mbr_row_unit.sv
// One-row step of the matrix rotation
`timescale 1ns/1ps

module mbr_row_unit
    import mbr_pkg::*;
(
    input  wire logic [15:0] i_row,     // Source row word
    input  wire logic        i_dir,     // 0 left, 1 right
    input  wire logic        i_fill,    // Bit entering this row
    output logic      [15:0] o_row,     // Rotated row word
    output logic             o_out_bit  // Bit leaving this row
);

    ////////////////////////////////////////////////////////////////////////
    // Shift by one place; the bit leaving goes on to the next row
    always_comb begin
        if (i_dir) begin
            // Right: fill enters at the top, bit 0 leaves
            o_row     = {i_fill, i_row[15:1]};   // RULE_02
            o_out_bit = i_row[0];                // RULE_10
        end else begin
            // Left: fill enters at the bottom, bit 15 leaves
            o_row     = {i_row[14:0], i_fill};   // RULE_02
            o_out_bit = i_row[15];               // RULE_10
        end
    end

endmodule // mbr_row_unit

// ### hdl/mbr_matrix_bit_rotate.sv
// Matrix bit rotator with APB registers and a word memory port
// Function
// (RULE_01) Rotate all rows together, one direction
// (RULE_02) Flag clear rotates left, set rotates right
// (RULE_03) Last rotated bit fills vacancy; result to destination
// (RULE_04) Last rotated bit also copied to carry
// (RULE_05) Program keeps row count within 1 to 256
// (RULE_06) Row beyond word area: skip, error, range code
// (RULE_07) Bad row count: skip, error, operand code
// (RULE_08) Each row one 16-bit word only
// (RULE_09) Program should start once per rising edge
// (RULE_10) Whole bit chain moves exactly one place
// (RULE_11) Skipped operation leaves destination and carry alone
`timescale 1ns/1ps

module mbr_matrix_bit_rotate
    import mbr_pkg::*;
(
    input  wire logic         i_clk,               // Core clock
    input  wire logic         i_rstn,              // Async reset, low
    input  wire logic         i_psel,              // APB select
    input  wire logic         i_penable,           // APB access phase
    input  wire logic         i_pwrite,            // APB write
    input  wire logic [7:0]   i_paddr,             // APB byte address
    input  wire logic [31:0]  i_pwdata,            // APB write data
    output logic      [31:0]  o_prdata,            // APB read data
    output logic              o_pready,            // APB ready
    output logic              o_pslverr,           // APB error
    output mbr_mem_req_s      o_mem,               // Word memory request
    input  wire mbr_mem_rsp_s i_mem,               // Word memory answer
    output logic              o_busy,              // Operation running
    output logic              o_error_flag,        // Error flag
    output logic              o_matrix_carry_flag, // Matrix carry flag
    output logic              o_irq                // Level interrupt
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic             direction_select_flag;  // 0 left, 1 right
    logic [15:0]      src_base;               // First source row
    logic [15:0]      dst_base;               // First destination row
    logic [15:0]      row_count;              // Rows per operation
    logic             error_flag;             // Sticky error flag
    logic             matrix_carry_flag;      // Last rotated bit
    logic [15:0]      error_code_register;    // Code of last refusal
    logic [IRQ_W-1:0] irq_stat;               // Sticky events
    logic [IRQ_W-1:0] irq_mask;               // Event enables
    mbr_state_e       state;                  // Engine state
    logic [7:0]       row_k;                  // Current row offset
    logic [8:0]       rows_left;              // Rows still to write
    logic             fill_bit;               // Bit entering next row
    mbr_mem_req_s     mem_req;                // Registered memory port
    logic             apb_setup;              // Setup phase
    logic             apb_wr;                 // Write takes effect
    logic             addr_ok;                // Address is mapped
    logic [31:0]      next_prdata;            // Read mux
    logic             start_go;               // Start request while idle, refused or not
    logic             count_bad;              // Row count out of range
    logic             range_bad;              // Area beyond word space
    logic             err_evt;                // Operation refused
    logic             done_evt;               // Operation finished
    logic [15:0]      row_new;                // Rotated row word
    logic             row_out_bit;            // Bit leaving the row
    logic [7:0]       next_k;                 // Following row offset
    logic [IRQ_W-1:0] irq_set;                // Events this cycle
    logic [IRQ_W-1:0] irq_clr;                // W1C this cycle
    logic             err_clr;                // Error flag W1C

    ////////////////////////////////////////////////////////////////////////
    // APB decode; zero wait states, so every access ends in one phase
    assign apb_setup = i_psel & ~i_penable;
    assign apb_wr    = i_psel & i_penable & i_pwrite;
    assign o_pready  = 1'b1;

    // Only the eight aligned words are mapped
    always_comb begin
        unique case (i_paddr)
            ADDR_CTRL, ADDR_SRC, ADDR_DST, ADDR_LEN, ADDR_STATUS,
            ADDR_ERRCODE, ADDR_IRQ_STAT, ADDR_IRQ_MASK: addr_ok = 1'b1;
            default:                                    addr_ok = 1'b0;
        endcase
    end

    // Unmapped accesses answer with an error and change nothing
    assign o_pslverr = i_psel & i_penable & ~addr_ok;

    // Read mux, unused bits read as zero
    always_comb begin
        next_prdata = 32'h0000_0000;
        unique case (i_paddr)
            ADDR_CTRL:     next_prdata[CTRL_DIR_BIT] = direction_select_flag;
            ADDR_SRC:      next_prdata[15:0] = src_base;
            ADDR_DST:      next_prdata[15:0] = dst_base;
            ADDR_LEN:      next_prdata[15:0] = row_count;
            ADDR_STATUS: begin
                next_prdata[STAT_BUSY_BIT]  = (state != ST_IDLE);
                next_prdata[STAT_ERR_BIT]   = error_flag;
                next_prdata[STAT_CARRY_BIT] = matrix_carry_flag;
            end
            ADDR_ERRCODE:  next_prdata[15:0] = error_code_register;
            ADDR_IRQ_STAT: next_prdata[IRQ_W-1:0] = irq_stat;
            ADDR_IRQ_MASK: next_prdata[IRQ_W-1:0] = irq_mask;
            default:       next_prdata = 32'h0000_0000;
        endcase
    end

    // Read data is caught in the setup phase and held through access
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_prdata <= 32'h0000_0000;
        end else if (apb_setup) begin
            o_prdata <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operand registers; frozen while an operation runs
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            direction_select_flag <= RST_BIT;
            src_base              <= RST_WORD;
            dst_base              <= RST_WORD;
            row_count             <= RST_LEN;
        end else if (apb_wr && state == ST_IDLE) begin
            unique case (i_paddr)
                ADDR_CTRL: direction_select_flag <= i_pwdata[CTRL_DIR_BIT];
                ADDR_SRC:  src_base  <= i_pwdata[15:0];
                ADDR_DST:  dst_base  <= i_pwdata[15:0];
                ADDR_LEN:  row_count <= i_pwdata[15:0];
                default: begin
                    // Other addresses hold no operand
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start and operand checks
    // A write of 1 to start while idle is one request, so at most one rotation per write
    assign start_go  = apb_wr && (i_paddr == ADDR_CTRL) &&
                       i_pwdata[CTRL_START_BIT] && (state == ST_IDLE); // RULE_09

    // Row count must be 1 to 256
    assign count_bad = (row_count < ROWS_MIN) ||
                       (row_count > ROWS_MAX);                          // RULE_07
    // Last source and destination rows must lie in the word area
    assign range_bad = (mbr_last_row(src_base, row_count) > AREA_LAST) ||
                       (mbr_last_row(dst_base, row_count) > AREA_LAST); // RULE_06

    assign err_evt   = start_go & (count_bad | range_bad);              // RULE_11
    assign done_evt  = (state == ST_WRITE) & i_mem.ack &
                       (rows_left == 9'h001);

    ////////////////////////////////////////////////////////////////////////
    // Row datapath, fed straight from the memory answer
    mbr_row_unit u_row (
        .i_row     (i_mem.rdata),
        .i_dir     (direction_select_flag),
        .i_fill    (fill_bit),
        .o_row     (row_new),
        .o_out_bit (row_out_bit)
    );

    // Left walks rows upward, right walks them downward
    assign next_k = direction_select_flag ? (row_k - 8'h01)
                                          : (row_k + 8'h01);    // RULE_10

    ////////////////////////////////////////////////////////////////////////
    // Engine: fetch the wrap bit, then read and write each row in turn
    // A destination overlapping the source ahead of the walk is corrupted
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state     <= ST_IDLE;
            row_k     <= 8'h00;
            rows_left <= 9'h000;
            fill_bit  <= RST_BIT;
            mem_req   <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    // A refused start leaves the memory untouched
                    if (start_go && !count_bad && !range_bad) begin   // RULE_11
                        state     <= ST_EDGE;
                        rows_left <= row_count[8:0];                  // RULE_01
                        mem_req.req <= 1'b1;
                        mem_req.we  <= 1'b0;
                        if (i_pwdata[CTRL_DIR_BIT]) begin
                            // Right: bit 0 of the first row wraps
                            row_k        <= row_count[7:0] - 8'h01;
                            mem_req.addr <= src_base;
                        end else begin
                            // Left: bit 15 of the last row wraps
                            row_k        <= 8'h00;
                            mem_req.addr <= 16'(mbr_last_row(src_base,
                                                             row_count));
                        end
                    end
                end
                ST_EDGE: begin
                    // The bit rotated last seeds the vacancy
                    if (i_mem.ack) begin
                        fill_bit <= direction_select_flag ?
                                    i_mem.rdata[0] : i_mem.rdata[15]; // RULE_03
                        mem_req.addr <= mbr_row_addr(src_base, row_k);
                        state        <= ST_READ;
                    end
                end
                ST_READ: begin
                    // Rotate the row as it arrives and queue its write
                    if (i_mem.ack) begin
                        mem_req.we    <= 1'b1;
                        mem_req.wdata <= row_new;                     // RULE_08
                        mem_req.addr  <= mbr_row_addr(dst_base, row_k); // RULE_03
                        fill_bit      <= row_out_bit;                 // RULE_10
                        state         <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    if (i_mem.ack) begin
                        rows_left  <= rows_left - 9'h001;
                        mem_req.we <= 1'b0;
                        if (rows_left == 9'h001) begin
                            // Last row written, release the memory
                            mem_req.req <= 1'b0;
                            state       <= ST_IDLE;
                        end else begin
                            row_k        <= next_k;
                            mem_req.addr <= mbr_row_addr(src_base, next_k);
                            state        <= ST_READ;
                        end
                    end
                end
            endcase
        end
    end

    assign o_mem  = mem_req;
    assign o_busy = (state != ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // Matrix carry: the bit leaving the last row is the one rotated last
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            matrix_carry_flag <= RST_BIT;
        end else if (done_evt) begin
            matrix_carry_flag <= fill_bit;                            // RULE_04
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error flag and error code; a new error wins over a clear
    assign err_clr = apb_wr && (i_paddr == ADDR_STATUS) &&
                     i_pwdata[STAT_ERR_BIT];

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            error_flag <= RST_BIT;
        end else if (err_evt) begin
            error_flag <= 1'b1;                                   // RULE_06
        end else if (err_clr) begin
            error_flag <= 1'b0;
        end
    end

    // Row count is judged before the area, since the area needs it
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            error_code_register <= RST_WORD;
        end else if (err_evt) begin
            error_code_register <= count_bad ? ERR_OPERAND    // RULE_07
                                             : ERR_RANGE;     // RULE_06
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, write one to clear, set wins over clear
    always_comb begin
        irq_set               = '0;
        irq_set[IRQ_DONE_BIT] = done_evt;
        irq_set[IRQ_ERR_BIT]  = err_evt;
    end

    assign irq_clr = (apb_wr && i_paddr == ADDR_IRQ_STAT) ?
                     i_pwdata[IRQ_W-1:0] : RST_IRQ;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_stat <= RST_IRQ;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
        end
    end

    // Mask register, same layout as the status
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_mask <= RST_IRQ;
        end else if (apb_wr && i_paddr == ADDR_IRQ_MASK) begin
            irq_mask <= i_pwdata[IRQ_W-1:0];
        end
    end

    // Level interrupt while any enabled event is pending
    assign o_irq               = |(irq_stat & irq_mask);
    assign o_error_flag        = error_flag;
    assign o_matrix_carry_flag = matrix_carry_flag;

endmodule // mbr_matrix_bit_rotate

// ### testbench/mbr_mem_model.sv
// Word memory of the sequencer, answering after a chosen number of cycles
`timescale 1ns/1ps
module mbr_mem_model
    import mbr_pkg::*;
(
    input  wire logic         i_clk,  // Core clock
    input  wire logic         i_rstn, // Async reset, low
    input  wire logic [3:0]   i_wait, // Extra cycles before an answer; the ack cycle counts as one for the next
    input  wire mbr_mem_req_s i_req,  // Request from the rotator
    output mbr_mem_rsp_s      o_rsp   // Answer to the rotator
);
    logic [15:0] mem [0:65535]; // Word device area
    logic [3:0]  cnt;           // Cycles waited so far

    // One ack pulse per held request; read data scrambled outside the ack
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt <= 4'h0;
            o_rsp <= '0;
        end else if (i_req.req && !o_rsp.ack && cnt >= i_wait) begin
            cnt <= 4'h0;
            o_rsp.ack <= 1'b1;
            o_rsp.rdata <= i_req.we ? ~o_rsp.rdata : mem[i_req.addr];
            if (i_req.we) mem[i_req.addr] <= i_req.wdata;
        end else begin
            cnt <= i_req.req ? cnt + 4'h1 : 4'h0;
            o_rsp.ack <= 1'b0;
            o_rsp.rdata <= ~o_rsp.rdata;
        end
    end
endmodule // mbr_mem_model

// ### testbench/mbr_checker.sv
// Port assertions of the matrix bit rotator
`timescale 1ns/1ps
module mbr_checker
    import mbr_pkg::*;
(
    input wire logic         i_clk,
    input wire logic         i_rstn,
    input wire logic         i_psel,
    input wire logic         i_penable,
    input wire logic         i_pwrite,
    input wire logic [7:0]   i_paddr,
    input wire logic [31:0]  i_pwdata,
    input wire logic         o_pslverr,
    input wire mbr_mem_req_s o_mem,
    input wire mbr_mem_rsp_s i_mem,
    input wire logic         o_busy,
    input wire logic         o_error_flag,
    input wire logic         o_matrix_carry_flag
);
    logic [15:0] src, dst, len, first; // Shadow operands, first address
    logic        dir, wr, go, bad_n, bad_a;
    assign wr = i_psel && i_penable && i_pwrite && !o_busy;
    assign go = wr && i_paddr == ADDR_CTRL && i_pwdata[0];
    assign bad_n = len < ROWS_MIN || len > ROWS_MAX;
    assign bad_a = {1'b0, src} + {1'b0, len} - 17'h1 > AREA_LAST
                || {1'b0, dst} + {1'b0, len} - 17'h1 > AREA_LAST;
    assign first = dir ? src : src + len - 16'h1;

    // Shadow of the operand registers, writes while busy are ignored
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            src <= RST_WORD;
            dst <= RST_WORD;
            len <= RST_LEN;
            dir <= RST_BIT;
        end else if (wr) begin
            if (i_paddr == ADDR_SRC) src <= i_pwdata[15:0];
            if (i_paddr == ADDR_DST) dst <= i_pwdata[15:0];
            if (i_paddr == ADDR_LEN) len <= i_pwdata[15:0];
            if (i_paddr == ADDR_CTRL) dir <= i_pwdata[CTRL_DIR_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    a_bad_count: assert property (go && bad_n |=> o_error_flag && !o_busy)
        else $error("bad count not flagged");
    a_bad_range: assert property (go && !bad_n && bad_a |=> o_error_flag)
        else $error("range error not flagged");
    a_skip_quiet: assert property (go && (bad_n || bad_a) |=>
        (!o_mem.req && $stable(o_matrix_carry_flag)) [*4])
        else $error("skip touched memory or carry");
    a_first_read: assert property (go && !bad_n && !bad_a |=>
        o_busy && o_mem.req && !o_mem.we && o_mem.addr == first)
        else $error("first read not the wrap row");
    a_carry_idle: assert property (!o_busy && !$past(o_busy) |->
        $stable(o_matrix_carry_flag)) else $error("carry moved while idle");
    a_req_hold: assert property (o_mem.req && !i_mem.ack |=> $stable(o_mem))
        else $error("memory request changed before ack");
    a_req_busy: assert property (o_mem.req |-> o_busy)
        else $error("memory request while idle");
    a_write_rows: assert property (o_mem.req && o_mem.we |->
        16'(o_mem.addr - dst) < len) else $error("write outside destination");
    a_pslverr_map: assert property (i_psel && i_penable |->
        o_pslverr == (i_paddr > ADDR_IRQ_MASK || i_paddr[1:0] != 2'h0))
        else $error("slave error on wrong address");
    c_left: cover property (go && !i_pwdata[1] && !bad_n && !bad_a);
    c_right: cover property (go && i_pwdata[1] && !bad_n && !bad_a);
    c_error: cover property (go && (bad_n || bad_a));
endmodule // mbr_checker

bind mbr_matrix_bit_rotate mbr_checker mbr_checker_inst (.i_clk, .i_rstn,
    .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pslverr, .o_mem,
    .i_mem, .o_busy, .o_error_flag, .o_matrix_carry_flag);

// ### testbench/mbr_matrix_bit_rotator_bench.sv
// Self-checking bench of the matrix bit rotator
`timescale 1ns/1ps
module mbr_matrix_bit_rotator_bench import mbr_pkg::*;;
    logic         clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0;
    logic         pwr = 1'b0, pready, pslverr, busy, err, carry, irq, se;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0, prdata, q;
    logic [3:0]   wt = 4'h0;
    mbr_mem_req_s mreq;
    mbr_mem_rsp_s mrsp;
    int           miscompares = 0;
    int           checks_done = 0;

    always #5 clk = ~clk;
    mbr_matrix_bit_rotate mbr_matrix_bit_rotate_inst (.i_clk(clk),
        .i_rstn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_mem(mreq), .i_mem(mrsp),
        .o_busy(busy), .o_error_flag(err), .o_matrix_carry_flag(carry),
        .o_irq(irq));
    mbr_mem_model mbr_mem_model_inst (.i_clk(clk), .i_rstn(rstn),
        .i_wait(wt), .i_req(mreq), .o_rsp(mrsp));

    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [32:0] g, input logic [32:0] e, string m);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    // One APB transfer, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) miscompares++;
        q = prdata;
        se = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask

    // Load memory, start an operation, check result, flags and events
    task automatic run(input logic [15:0] s, d, n, input logic dr,
                       input logic [3:0] w, input logic [15:0] code);
        logic [15:0] img [0:255];
        logic [15:0] e;
        logic        c;
        int          k;
        for (k = 0; k < 256; k++) begin
            img[k] = 16'hA5C3 ^ (16'(k) * 16'h1357);
            mbr_mem_model_inst.mem[d + 16'(k)] = 16'hDEAD;
            mbr_mem_model_inst.mem[s + 16'(k)] = img[k];
        end
        c = (code != 0) ? carry : (dr ? img[0][0] : img[n[7:0] - 8'h1][15]);
        wt <= w;
        apb(1, ADDR_SRC, s);
        apb(1, ADDR_DST, d);
        apb(1, ADDR_LEN, n);
        apb(1, ADDR_CTRL, {dr, 1'b1});
        apb(1, ADDR_CTRL, {dr, 1'b1});
        for (k = 0; k < 8000 && busy !== 1'b0; k++) @(posedge clk);
        apb(0, ADDR_STATUS, 0);
        chk(q, {c, code != 0, 1'b0}, "status");
        for (k = 0; k < n && code == 0; k++) begin
            e = dr ? {img[(k + 1) % n][0], img[k][15:1]}
                   : {img[k][14:0], img[(k + n - 1) % n][15]};
            chk(mbr_mem_model_inst.mem[d + 16'(k)], e, "row");
        end
        apb(0, ADDR_ERRCODE, 0);
        if (code != 0) chk(q, code, "code");
        if (code != 0) chk(mbr_mem_model_inst.mem[d], 16'hDEAD, "dst");
        apb(0, ADDR_IRQ_STAT, 0);
        chk({q, irq}, (code != 0) ? 33'h5 : 33'h3, "event");
        apb(1, ADDR_IRQ_MASK, 0);
        chk(irq, 0, "masked");
        apb(1, ADDR_IRQ_MASK, 3);
        apb(1, ADDR_IRQ_STAT, 3);
        apb(1, ADDR_STATUS, 2);
        chk({irq, err}, 0, "cleared");
    endtask

    task automatic results();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        apb(0, ADDR_LEN, 0);
        chk(q, 1, "len reset");
        apb(0, 8'h20, 0);
        chk({q, se}, 1, "unmapped");
        apb(1, ADDR_IRQ_MASK, 3);
        run(16'h0100, 16'h0200, 3, 0, 0, 0);
        run(16'h0100, 16'h0200, 3, 1, 2, 0);
        run(16'h0300, 16'h0300, 5, 0, 3, 0);
        run(16'h0300, 16'h0300, 4, 1, 3, 0);
        run(16'h1000, 16'h2000, 1, 0, 0, 0);
        run(16'h1000, 16'h2000, 256, 1, 0, 0);
        run(16'hFFFE, 16'h0200, 2, 0, 1, 0);
        run(16'h0100, 16'h0200, 0, 0, 0, ERR_OPERAND);
        run(16'h0100, 16'h0200, 257, 1, 0, ERR_OPERAND);
        run(16'hFFFF, 16'h0200, 2, 0, 0, ERR_RANGE);
        run(16'h0100, 16'hFFFE, 3, 1, 0, ERR_RANGE);
        results();
    end

    // Watchdog against a hang
    initial begin
        #300000;
        miscompares++;
        results();
    end
endmodule // mbr_matrix_bit_rotator_bench
